// [hdl/bdma_defs.svh]
// Purpose: constants for the banked data memory addressing block
// Assumes: included by its bare name from package and modules
// Notes: offsets, field positions, reset values of the register file
// Contract
// [RULE1] Current bank comes from the top three bank pointer bits.
// [RULE2] Bank instruction changes only the three bank bits; full write replaces all.
// [RULE3] Reset leaves the bank pointer selecting bank 0.
// [RULE4] Each access carries a 5-bit select field, 32 locations per bank.
// [RULE5] Selects 00h-0Fh reach the same sixteen global registers in every bank.
// [RULE6] First eight globals are dedicated registers, the next eight general purpose.
// [RULE7] Selects 10h-1Fh reach per-bank registers at bank times 20h plus select.
// [RULE8] 136 general-purpose registers: 24 in bank 0, 16 in banks 1-7.
// [RULE9] Without port C its location serves as one more general register.
// [RULE10] Select 00h accesses indirectly, the bank pointer being the full address.
// [RULE11] Bank pointer is itself the global register at location 04h.
// [RULE12] Selects 01h-0Fh reach the global register directly, ignoring the pointer.
// [RULE13] Selects 10h-1Fh take bank from pointer top bits, register from field.
// [RULE14] Every data-memory register is eight bits wide.
// [RULE15] Larger variant uses sixteen banks of sixteen bytes, globals separate.
// [RULE16] Indirect pointer with bit 4 clear reaches global given by low bits.
`ifndef BDMA_DEFS_SVH
`define BDMA_DEFS_SVH

// ****************************************
// Register offsets within the global bank
// ****************************************
`define BDMA_OFS_INDIRECT 8'h00
`define BDMA_OFS_RTC 8'h01
`define BDMA_OFS_PC_LOW 8'h02
`define BDMA_OFS_STATUS 8'h03
`define BDMA_OFS_BANK_PTR 8'h04
`define BDMA_OFS_PORT_A 8'h05
`define BDMA_OFS_PORT_B 8'h06
`define BDMA_OFS_PORT_C 8'h07

// ****************************************
// Field positions and sizes
// ****************************************
`define BDMA_FR_W 5
`define BDMA_FR_UPPER_BIT 4
`define BDMA_DATA_W 8
`define BDMA_IDX_W 9
`define BDMA_GLOBAL_COUNT 16
`define BDMA_DEDICATED_COUNT 8
`define BDMA_BANK8_LSB 5
`define BDMA_BANK16_LSB 4
`define BDMA_BANK_SEL_LSB8 5
`define BDMA_BANK_SEL_LSB16 4

// ****************************************
// Reset values
// ****************************************
`define BDMA_BP_RESET 8'h00
`define BDMA_DATA_RESET 8'h00

`endif

// [hdl/bdma_pkg.sv]
// Purpose: shared types of the banked data memory addressing block
// Assumes: bdma_defs.svh on the include path
// Notes: types only, every number but the mode codes lives in the header
`include "bdma_defs.svh"

package bdma_pkg;

  // ****************************************
  // Addressing modes
  // ****************************************
  typedef enum logic [1:0] {
    BDMA_MODE_INDIRECT = 2'b00,
    BDMA_MODE_GLOBAL = 2'b01,
    BDMA_MODE_BANKED = 2'b10
  } bdma_mode_type;

  // Request from the instruction execution logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`BDMA_FR_W-1:0] fr;
    logic [`BDMA_DATA_W-1:0] wdata;
  } bdma_access_type;

  // Resolved target of one access
  typedef struct packed {
    bdma_mode_type mode;
    logic global_hit;
    logic is_bp;
    logic is_null;
    logic [`BDMA_DATA_W-1:0] addr;
    logic [`BDMA_IDX_W-1:0] idx;
  } bdma_target_type;

endpackage

// [hdl/bdma_store.sv]
// Purpose: flip-flop storage for the global and banked registers
// Assumes: one write port, one combinational read port
// Notes: every entry is one byte, cleared by reset
`timescale 1ns/100ps
`include "bdma_defs.svh"

module bdma_store #(
  parameter int DEPTH = 144
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Write port
  input wire logic wr_en,
  input wire logic [`BDMA_IDX_W-1:0] wr_idx,
  input wire logic [`BDMA_DATA_W-1:0] wr_data,
  // Read port
  input wire logic [`BDMA_IDX_W-1:0] rd_idx,
  output logic [`BDMA_DATA_W-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][`BDMA_DATA_W-1:0] mem;
  } bdma_store_state_type;

  bdma_store_state_type st_r;
  bdma_store_state_type st_nxt;

  // ****************************************
  // Storage update
  // ****************************************
  // Out-of-range index is dropped rather than aliased
  always_comb begin
    st_nxt = st_r;
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      st_nxt.mem[wr_idx] = wr_data; // [RULE14]
    end
  end

  // Register the copy
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read path, zero beyond the array
  assign rd_data = (int'(rd_idx) < DEPTH) ? st_r.mem[rd_idx] : `BDMA_DATA_RESET;

endmodule

// [hdl/bdma_top.sv]
// Purpose: resolve the register select field into a data-memory location
// Assumes: requests come from core logic on core_clk, no synchroniser needed
// Notes: read data appears one cycle after the request
`timescale 1ns/100ps
`include "bdma_defs.svh"

module bdma_top #(
  parameter bit BANKS16 = 1'b0,
  parameter bit HAS_PORT_C = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Access request from the instruction execution logic
  input wire bdma_pkg::bdma_access_type access,
  // Bank instruction
  input wire logic bank_sel_en,
  input wire logic [2:0] bank_sel_value,
  // Read answer
  output logic rd_valid,
  output logic [`BDMA_DATA_W-1:0] rd_data,
  // Resolved location of the last access
  output logic acc_valid,
  output logic [`BDMA_DATA_W-1:0] acc_addr,
  output logic acc_global,
  output logic acc_dedicated,
  output bdma_pkg::bdma_mode_type acc_mode,
  // Bank pointer view
  output logic [`BDMA_DATA_W-1:0] bank_pointer,
  output logic [3:0] current_bank
);

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NBANKS = BANKS16 ? 16 : 8;
  localparam int BANK_BYTES = 16;
  localparam int DEPTH = `BDMA_GLOBAL_COUNT + NBANKS * BANK_BYTES;
  localparam int BANK_LSB = BANKS16 ? `BDMA_BANK16_LSB : `BDMA_BANK8_LSB;
  localparam int SEL_LSB = BANKS16 ? `BDMA_BANK_SEL_LSB16 : `BDMA_BANK_SEL_LSB8;
  localparam logic [`BDMA_IDX_W-1:0] GLOBAL_BASE = `BDMA_IDX_W'(`BDMA_GLOBAL_COUNT);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [`BDMA_DATA_W-1:0] bp;
    logic rd_valid;
    logic [`BDMA_DATA_W-1:0] rd_data;
    logic acc_valid;
    logic [`BDMA_DATA_W-1:0] acc_addr;
    logic acc_global;
    logic acc_dedicated;
    bdma_pkg::bdma_mode_type acc_mode;
  } bdma_top_state_type;

  bdma_top_state_type st_r;
  bdma_top_state_type st_nxt;

  bdma_pkg::bdma_target_type tgt;
  logic [`BDMA_DATA_W-1:0] store_rdata;
  logic store_wr;
  logic [`BDMA_DATA_W-1:0] bp_full;
  logic [2:0] bank_bits;

  // ****************************************
  // Resolution function
  // ****************************************
  // Global entry helper
  function automatic bdma_pkg::bdma_target_type mk_global(
    input logic [3:0] loc,
    input bdma_pkg::bdma_mode_type mode
  );
    bdma_pkg::bdma_target_type t;
    t = '0;
    t.mode = mode;
    t.global_hit = 1'b1;
    t.addr = {4'h0, loc};
    t.idx = {5'h00, loc};
    t.is_bp = ({4'h0, loc} == `BDMA_OFS_BANK_PTR); // [RULE11]
    t.is_null = ({4'h0, loc} == `BDMA_OFS_INDIRECT);
    return t;
  endfunction

  // Banked entry helper, bank and byte within the stored upper half
  function automatic bdma_pkg::bdma_target_type mk_banked(
    input logic [3:0] bank,
    input logic [3:0] loc,
    input logic [`BDMA_DATA_W-1:0] addr,
    input bdma_pkg::bdma_mode_type mode
  );
    bdma_pkg::bdma_target_type t;
    t = '0;
    t.mode = mode;
    t.addr = addr;
    t.idx = GLOBAL_BASE + {1'b0, bank, loc};
    return t;
  endfunction

  // Map select field and pointer onto a storage entry
  function automatic bdma_pkg::bdma_target_type resolve(
    input logic [`BDMA_FR_W-1:0] fr,
    input logic [`BDMA_DATA_W-1:0] bp
  );
    bdma_pkg::bdma_target_type t;
    logic [3:0] bank8;
    logic [3:0] bank16;
    bank8 = {1'b0, bp[7:5]};
    bank16 = bp[7:4];
    t = '0;
    if (fr == 5'h00) begin
      // Indirect: the whole pointer is the address, only its low four bits with eight banks and bit 4 clear
      if (BANKS16) begin
        if (bank16 == 4'h0) begin
          t = mk_global(bp[3:0], bdma_pkg::BDMA_MODE_INDIRECT); // [RULE15]
        end else begin
          t = mk_banked(bank16, bp[3:0], bp, bdma_pkg::BDMA_MODE_INDIRECT); // [RULE15]
        end
      end else if (!bp[`BDMA_FR_UPPER_BIT]) begin
        t = mk_global(bp[3:0], bdma_pkg::BDMA_MODE_INDIRECT); // [RULE16]
      end else begin
        t = mk_banked(bank8, bp[3:0], bp, bdma_pkg::BDMA_MODE_INDIRECT); // [RULE10]
      end
    end else if (!fr[`BDMA_FR_UPPER_BIT]) begin
      // Direct global, pointer ignored
      t = mk_global(fr[3:0], bdma_pkg::BDMA_MODE_GLOBAL); // [RULE12] [RULE5]
    end else if (BANKS16) begin
      // Four pointer bits pick one of sixteen banks
      t = mk_banked(bank16, fr[3:0], {bank16, fr[3:0]},
        bdma_pkg::BDMA_MODE_BANKED); // [RULE15]
    end else begin
      // Bank times 20h plus the select value
      t = mk_banked(bank8, fr[3:0], {bp[7:5], fr},
        bdma_pkg::BDMA_MODE_BANKED); // [RULE7] [RULE13]
    end
    return t;
  endfunction

  // ****************************************
  // Decode of the current request
  // ****************************************
  // The full field is decoded, all 32 values reach a location
  always_comb begin
    tgt = resolve(access.fr, st_r.bp); // [RULE4]
  end

  // Indirect port pointing at itself holds no storage
  assign store_wr = access.wr && !tgt.is_bp && !tgt.is_null;

  // Full write replaces every pointer bit
  assign bp_full = (access.wr && tgt.is_bp) ? access.wdata : st_r.bp; // [RULE2]

  // Bank instruction bits, applied after a full write in the same cycle
  assign bank_bits = bank_sel_en ? bank_sel_value : bp_full[SEL_LSB +: 3];

  // ****************************************
  // Next state
  // ****************************************
  // Bank instruction touches only three bits, so it cannot reach bit 7 of the
  // larger variant; software must write the full pointer for that
  always_comb begin
    st_nxt = st_r;
    st_nxt.bp = bp_full;
    st_nxt.bp[SEL_LSB +: 3] = bank_bits; // [RULE2]
    st_nxt.rd_valid = access.rd;
    st_nxt.acc_valid = access.rd || access.wr;
    if (access.rd) begin
      // Read returns the value before any write of the same cycle
      if (tgt.is_bp) begin
        st_nxt.rd_data = st_r.bp; // [RULE11]
      end else if (tgt.is_null) begin
        st_nxt.rd_data = `BDMA_DATA_RESET;
      end else begin
        st_nxt.rd_data = store_rdata; // [RULE14]
      end
    end
    if (access.rd || access.wr) begin
      st_nxt.acc_addr = tgt.addr;
      st_nxt.acc_global = tgt.global_hit;
      st_nxt.acc_mode = tgt.mode;
      // Without port C its slot counts as general purpose
      st_nxt.acc_dedicated = tgt.global_hit &&
        (tgt.addr < `BDMA_DATA_W'(`BDMA_DEDICATED_COUNT)) &&
        (HAS_PORT_C || (tgt.addr != `BDMA_OFS_PORT_C)); // [RULE6] [RULE9]
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r.bp <= `BDMA_BP_RESET; // [RULE3]
      st_r.rd_valid <= 1'b0;
      st_r.rd_data <= `BDMA_DATA_RESET;
      st_r.acc_valid <= 1'b0;
      st_r.acc_addr <= `BDMA_DATA_RESET;
      st_r.acc_global <= 1'b0;
      st_r.acc_dedicated <= 1'b0;
      st_r.acc_mode <= bdma_pkg::BDMA_MODE_INDIRECT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Storage: sixteen globals plus the banked bytes
  // ****************************************
  // 8-bank variant: 16 + 128 entries, bank 0 upper half included
  bdma_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(store_wr), // [RULE8]
    .wr_idx(tgt.idx),
    .wr_data(access.wdata),
    .rd_idx(tgt.idx),
    .rd_data(store_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_valid = st_r.rd_valid;
  assign rd_data = st_r.rd_data;
  assign acc_valid = st_r.acc_valid;
  assign acc_addr = st_r.acc_addr;
  assign acc_global = st_r.acc_global;
  assign acc_dedicated = st_r.acc_dedicated;
  assign acc_mode = st_r.acc_mode;
  assign bank_pointer = st_r.bp;
  // Top pointer bits name the current bank
  assign current_bank = BANKS16 ? st_r.bp[7:4] : {1'b0, st_r.bp[7:5]}; // [RULE1]

endmodule

// [hdl/bdma_pkg_dummy_note.sv]
`include "bdma_defs.svh"

// [verif/bdma_top_checker.sv]
// Purpose: port-level checks of the banked addressing block
// Assumes: eight-bank build, one clock, synchronous reset
// Notes: bound to bdma_top after the module
`timescale 1ns/100ps
`include "bdma_defs.svh"

module bdma_top_checker #(
  parameter bit BANKS16 = 1'b0,
  parameter bit HAS_PORT_C = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Requests
  input wire bdma_pkg::bdma_access_type access,
  input wire logic bank_sel_en,
  input wire logic [2:0] bank_sel_value,
  // Answers
  input wire logic rd_valid,
  input wire logic [`BDMA_DATA_W-1:0] rd_data,
  input wire logic acc_valid,
  input wire logic [`BDMA_DATA_W-1:0] acc_addr,
  input wire logic acc_global,
  input wire logic acc_dedicated,
  input wire bdma_pkg::bdma_mode_type acc_mode,
  input wire logic [`BDMA_DATA_W-1:0] bank_pointer,
  input wire logic [3:0] current_bank
);
  // ****
  // Helpers and sequences
  // ****
  logic [7:0] prev_bp_r;
  // Pointer as the decode saw it, so slices need no sampled function
  always_ff @(posedge core_clk) begin
    prev_bp_r <= bank_pointer;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_req;
    access.rd || access.wr;
  endsequence
  sequence s_direct;
    s_req ##0 (access.fr != 5'h00 && !access.fr[4]);
  endsequence
  sequence s_banked;
    s_req ##0 access.fr[4];
  endsequence
  // ****
  // Assertions
  // ****
  chk_read_answer: assert property (access.rd |=> rd_valid)
    else $error("read got no answer");
  chk_idle_quiet: assert property (!(access.rd || access.wr) |=>
    !acc_valid && $stable(acc_addr))
    else $error("answer without access");
  chk_access_answer: assert property (s_req |=> acc_valid)
    else $error("access got no answer");
  chk_bank_view: assert property (
    !BANKS16 |-> current_bank == {1'b0, bank_pointer[7:5]})
    else $error("current bank not from top pointer bits");
  chk_reset_bank: assert property ($fell(srst) |-> bank_pointer == 8'h00)
    else $error("bank pointer not cleared by reset");
  chk_bank_bits: assert property (bank_sel_en && !access.wr |=>
    bank_pointer == {$past(bank_sel_value), prev_bp_r[4:0]})
    else $error("bank instruction touched other bits");
  chk_full_write: assert property (
    access.wr && access.fr == 5'h04 && !bank_sel_en |=> bank_pointer == $past(access.wdata))
    else $error("full pointer write lost");
  chk_direct_global: assert property (s_direct |=>
    acc_mode == bdma_pkg::BDMA_MODE_GLOBAL && acc_global && acc_addr == {3'h0, $past(access.fr)})
    else $error("direct access not global");
  chk_banked_addr: assert property (s_banked |=>
    acc_mode == bdma_pkg::BDMA_MODE_BANKED && !acc_global &&
    acc_addr == {prev_bp_r[7:5], $past(access.fr)})
    else $error("banked address wrong");
  chk_indirect_addr: assert property (
    s_req ##0 (access.fr == 5'h00 && bank_pointer[4]) |=>
    acc_mode == bdma_pkg::BDMA_MODE_INDIRECT && acc_addr == prev_bp_r)
    else $error("indirect address wrong");
  // Dedicated flag only on the low globals, port C slot freed when absent
  chk_dedicated_map: assert property (acc_valid && acc_dedicated |->
    acc_global && acc_addr < 8'h08 && (HAS_PORT_C || acc_addr != 8'h07))
    else $error("dedicated flag outside dedicated globals");
endmodule

bind bdma_top bdma_top_checker #(.BANKS16(BANKS16), .HAS_PORT_C(HAS_PORT_C)) u_chk (
  .core_clk, .srst, .access, .bank_sel_en, .bank_sel_value, .rd_valid, .rd_data, .acc_valid,
  .acc_addr, .acc_global, .acc_dedicated, .acc_mode, .bank_pointer, .current_bank);

// [verif/bdma_core_model.sv]
// Purpose: instruction execution side that issues register accesses
// Assumes: one instruction per call, changed just after a rising edge
// Notes: idle cycles keep random field values, only strobes drop
`timescale 1ns/100ps

module bdma_core_model (
  // Clock
  input wire logic core_clk,
  // Requests toward the block
  output bdma_pkg::bdma_access_type access,
  output logic bank_sel_en,
  output logic [2:0] bank_sel_value
);
  // Quiet until the first instruction
  initial begin
    access = '0;
    bank_sel_en = 1'b0;
    bank_sel_value = 3'h0;
  end
  // Whole instruction in one cycle; 5-bit select always sent complete
  task automatic issue(input bdma_pkg::bdma_access_type a, input logic be, input logic [2:0] bv);
    @(posedge core_clk);
    access <= a;
    bank_sel_en <= be;
    bank_sel_value <= bv;
  endtask
endmodule

// [verif/bdma_top_tb_top.sv]
// Purpose: self-checking bench of the banked addressing block
// Assumes: default build, eight banks with port C
// Notes: a reference map predicts every answer into a note queue
`timescale 1ns/100ps
`include "bdma_defs.svh"

module bdma_top_tb_top;
  typedef struct packed {
    logic rd;
    logic [7:0] data;
    logic [7:0] addr;
    logic chk_addr;
    bdma_pkg::bdma_mode_type mode;
    logic glob;
    logic ded;
    logic ded_nc;
    logic [7:0] bp;
  } bdma_note_type;
  logic acc_dedicated_nc;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  bdma_pkg::bdma_access_type access;
  logic bank_sel_en, rd_valid, acc_valid, acc_global, acc_dedicated;
  logic [2:0] bank_sel_value;
  logic [7:0] rd_data, acc_addr, bank_pointer, bp_m;
  logic [3:0] current_bank;
  bdma_pkg::bdma_mode_type acc_mode;
  logic [7:0] mem_m [256];
  logic [31:0] seed = 32'h0000_ce39;
  bdma_note_type notes[$];
  bdma_note_type e;
  int fail_count = 0;
  int samples_checked = 0;

  always #4 core_clk = ~core_clk;

  bdma_top dut (.core_clk, .srst, .access, .bank_sel_en, .bank_sel_value, .rd_valid, .rd_data,
    .acc_valid, .acc_addr, .acc_global, .acc_dedicated, .acc_mode, .bank_pointer, .current_bank);
  // Build without port C, only its dedicated flag is compared
  bdma_top #(.HAS_PORT_C(1'b0)) dut_nc (.core_clk, .srst, .access, .bank_sel_en,
    .bank_sel_value, .rd_valid(), .rd_data(), .acc_valid(), .acc_addr(), .acc_global(),
    .acc_dedicated(acc_dedicated_nc), .acc_mode(), .bank_pointer(), .current_bank());
  bdma_core_model core (.core_clk, .access, .bank_sel_en, .bank_sel_value);

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Predict before updating: same-cycle read sees the old byte
  task automatic step(input logic rd, wr, input logic [4:0] fr, input logic [7:0] wd,
                      input logic be, input logic [2:0] bv);
    bdma_note_type n;
    logic [7:0] k;
    k = fr[4] ? {bp_m[7:5], fr} : {3'h0, fr};
    if (fr == 5'h00) k = bp_m[4] ? bp_m : {4'h0, bp_m[3:0]};
    n.rd = rd;
    n.data = (k == 8'h00) ? 8'h00 : (k == 8'h04 ? bp_m : mem_m[k]);
    n.addr = k;
    n.chk_addr = 1'b1;
    n.mode = fr[4] ? bdma_pkg::BDMA_MODE_BANKED : bdma_pkg::BDMA_MODE_GLOBAL;
    if (fr == 5'h00) n.mode = bdma_pkg::BDMA_MODE_INDIRECT;
    n.glob = k < 8'h10;
    n.ded = k < 8'h08;
    n.ded_nc = n.ded && k != 8'h07;
    if (wr && k == 8'h04) bp_m = wd;
    else if (wr && k != 8'h00) mem_m[k] = wd;
    if (be) bp_m[7:5] = bv;
    n.bp = bp_m;
    if (rd || wr) notes.push_back(n);
    core.issue({rd, wr, fr, wd}, be, bv);
  endtask

  // Monitor: each answer takes the oldest note
  always @(negedge core_clk) begin
    if (acc_valid === 1'b1) begin
      if (notes.size() == 0) check(8'h01, 8'h00);
      else begin
        e = notes.pop_front();
        check(rd_valid, e.rd);
        if (e.rd) check(rd_data, e.data);
        if (e.chk_addr) check(acc_addr, e.addr);
        check(acc_mode, e.mode);
        check({acc_global, acc_dedicated}, {e.glob, e.ded});
        check(acc_dedicated_nc, e.ded_nc);
        check(bank_pointer, e.bp);
        check({4'h0, current_bank}, {5'h00, e.bp[7:5]});
      end
    end else if (srst === 1'b0) check(rd_valid, 1'b0);
  end

  // Main sequence: directed walk, bank sweep, then random traffic
  initial begin
    for (int i = 0; i < 256; i++) mem_m[i] = 8'h00;
    bp_m = 8'h00;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    step(1, 0, 5'h04, 8'h00, 0, 0);
    step(0, 1, 5'h04, 8'hf5, 0, 0);
    step(0, 1, 5'h00, 8'h01, 0, 0);
    step(1, 0, 5'h15, 8'h00, 0, 0);
    step(0, 1, 5'h0f, 8'ha5, 0, 0);
    step(1, 1, 5'h07, 8'h3c, 0, 0);
    for (int b = 0; b < 8; b++) begin
      step(0, 1, 5'h1f, b[7:0], 1, b[2:0]);
      step(1, 0, 5'h0f, 8'h00, 0, 0);
    end
    step(0, 1, 5'h04, 8'h0c, 0, 0);
    step(1, 0, 5'h00, 8'h00, 0, 0);
    repeat (800) begin
      seed = xorshift(seed);
      step(seed[0], seed[1], seed[6:2], seed[15:8], seed[16] & seed[17], seed[20:18]);
    end
    step(0, 0, 5'h00, 8'h00, 0, 0);
    for (int i = 0; i < 8 && notes.size() > 0; i++) @(posedge core_clk);
    if (notes.size() != 0) check(8'h01, 8'h00);
    stop_test();
  end
endmodule
